// ### verilog/cfi_pkg.sv
// constants, types and codes shared by the core flags / indirect / irq datapath
package cfi_pkg;

	// data space map
	localparam logic [7:0] CFI_ADDR_IND0  = 8'h00;
	localparam logic [7:0] CFI_ADDR_PTR0  = 8'h01;
	localparam logic [7:0] CFI_ADDR_IND1  = 8'h02;
	localparam logic [7:0] CFI_ADDR_PTR1  = 8'h03;
	localparam logic [7:0] CFI_ADDR_WREG  = 8'h05;
	localparam logic [7:0] CFI_ADDR_FLAGS = 8'h0a;
	localparam logic [7:0] CFI_ADDR_ICR   = 8'h0b;
	localparam logic [7:0] CFI_ADDR_RAM   = 8'h20;

	// flags register fields
	localparam int CFI_FLG_CARRY  = 0;
	localparam int CFI_FLG_HALF   = 1;
	localparam int CFI_FLG_ZERO   = 2;
	localparam int CFI_FLG_RANGE  = 3;
	localparam int CFI_FLG_HALTED = 4;
	localparam int CFI_FLG_WDX    = 5;

	// interrupt control register fields (enables at bits 1..3, pendings at 4..6)
	localparam int CFI_ICR_GIE     = 0;
	localparam int CFI_ICR_ALLOW_LO = 1;
	localparam int CFI_ICR_PEND_LO = 4;
	localparam int CFI_NUM_SRC     = 3;

	// service addresses, index 0 = external, 1 = timer 0, 2 = timer 1
	localparam logic [7:0] CFI_VEC_EXT = 8'h04;
	localparam logic [7:0] CFI_VEC_T0  = 8'h08;
	localparam logic [7:0] CFI_VEC_T1  = 8'h0c;

	// values after reset
	localparam logic [7:0] CFI_RST_BYTE = 8'h00;
	localparam logic       CFI_RST_PIN  = 1'b1;

	typedef enum logic [2:0] {
		CFI_CMD_NOP   = 3'h0,
		CFI_CMD_READ  = 3'h1,
		CFI_CMD_STORE = 3'h2,
		CFI_CMD_LOAD  = 3'h3,
		CFI_CMD_IMM   = 3'h6,
		CFI_CMD_ALU   = 3'h7
	} cfi_cmd_t;

	typedef enum logic [4:0] {
		CFI_OP_ADD = 5'h00, CFI_OP_ADC = 5'h01, CFI_OP_SUB = 5'h02, CFI_OP_SBC = 5'h03,
		CFI_OP_DAA = 5'h04, CFI_OP_AND = 5'h05, CFI_OP_OR  = 5'h06, CFI_OP_XOR = 5'h07,
		CFI_OP_CPL = 5'h08, CFI_OP_RL  = 5'h09, CFI_OP_RR  = 5'h0a, CFI_OP_RLC = 5'h0b,
		CFI_OP_RRC = 5'h0c, CFI_OP_INC = 5'h0d, CFI_OP_DEC = 5'h0e, CFI_OP_SZ  = 5'h0f,
		CFI_OP_SNZ = 5'h10, CFI_OP_SIZ = 5'h11, CFI_OP_SDZ = 5'h12
	} cfi_alu_op_t;

endpackage

// ### verilog/cfi_core_if.sv
// signals between the core datapath and its ALU and interrupt arbiter
`timescale 1ns/1ps
interface cfi_core_if;
	import cfi_pkg::*;
	cfi_alu_op_t                   op;
	logic [7:0]                    a;
	logic [7:0]                    b;
	logic                          cin_c;
	logic                          cin_ac;
	logic [7:0]                    res;
	logic                          c;
	logic                          ac;
	logic                          ov;
	logic                          z;
	logic                          m_c;
	logic                          m_av;
	logic                          m_z;
	logic                          store;
	logic                          skip;
	logic [CFI_NUM_SRC-1:0]        pend;
	logic [CFI_NUM_SRC-1:0]        allow;
	logic                          gie;
	logic                          stack_full;
	logic                          boundary;
	logic                          take;
	logic [CFI_NUM_SRC-1:0]        sel;

	modport alu (input op, a, b, cin_c, cin_ac,
		output res, c, ac, ov, z, m_c, m_av, m_z, store, skip);
	modport arb (input pend, allow, gie, stack_full, boundary, output take, sel);
	modport core (output op, a, b, cin_c, cin_ac, pend, allow, gie, stack_full, boundary,
		input res, c, ac, ov, z, m_c, m_av, m_z, store, skip, take, sel);
endinterface

// ### verilog/cfi_alu.sv
// eight-bit ALU: arithmetic, logic, rotate, step and skip tests with flag outputs
`timescale 1ns/1ps
module cfi_alu (
	cfi_core_if.alu u
);
	import cfi_pkg::*;

	logic       sub;
	logic       cin;
	logic [7:0] bb;
	logic [8:0] sum9;
	logic [4:0] lo5;
	logic [7:0] s8;
	logic [8:0] t9;

	// shared adder; subtraction adds the complement so carry means no borrow
	always_comb
	begin
		sub  = (u.op == CFI_OP_SUB) || (u.op == CFI_OP_SBC);
		bb   = sub ? ~u.b : u.b;
		cin  = ((u.op == CFI_OP_ADC) || (u.op == CFI_OP_SBC)) ? u.cin_c : sub;
		sum9 = {1'b0, u.a} + {1'b0, bb} + {8'h00, cin};
		lo5  = {1'b0, u.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
		s8   = {1'b0, u.a[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};
		t9   = {1'b0, u.b};
		if ((u.b[3:0] > 4'h9) || u.cin_ac)
			t9 = t9 + 9'h006;
		if ((t9[7:4] > 4'h9) || u.cin_c || t9[8])
			t9 = t9 + 9'h060;
	end

	// result and which flags the operation owns
	always_comb
	begin
		u.res   = u.b;
		u.c     = sum9[8];
		u.ac    = lo5[4];
		u.ov    = s8[7] ^ sum9[8];
		u.m_c   = 1'b0;
		u.m_av  = 1'b0;
		u.m_z   = 1'b0;
		u.store = 1'b1;
		case (u.op)
			CFI_OP_ADD, CFI_OP_ADC, CFI_OP_SUB, CFI_OP_SBC:
			begin
				u.res  = sum9[7:0];
				u.m_c  = 1'b1;
				u.m_av = 1'b1;
				u.m_z  = 1'b1;
			end
			CFI_OP_DAA:
			begin
				u.res = t9[7:0];
				u.c   = t9[8] | u.cin_c;
				u.m_c = 1'b1;
			end
			CFI_OP_AND: begin u.res = u.a & u.b; u.m_z = 1'b1; end
			CFI_OP_OR:  begin u.res = u.a | u.b; u.m_z = 1'b1; end
			CFI_OP_XOR: begin u.res = u.a ^ u.b; u.m_z = 1'b1; end
			CFI_OP_CPL: begin u.res = ~u.b; u.m_z = 1'b1; end
			CFI_OP_RL:  u.res = {u.b[6:0], u.b[7]};
			CFI_OP_RR:  u.res = {u.b[0], u.b[7:1]};
			CFI_OP_RLC: begin u.res = {u.b[6:0], u.cin_c}; u.c = u.b[7]; u.m_c = 1'b1; end
			CFI_OP_RRC: begin u.res = {u.cin_c, u.b[7:1]}; u.c = u.b[0]; u.m_c = 1'b1; end
			CFI_OP_INC: begin u.res = u.b + 8'h01; u.m_z = 1'b1; end
			CFI_OP_DEC: begin u.res = u.b - 8'h01; u.m_z = 1'b1; end
			CFI_OP_SIZ: u.res = u.b + 8'h01;
			CFI_OP_SDZ: u.res = u.b - 8'h01;
			CFI_OP_SZ, CFI_OP_SNZ: u.store = 1'b0;
			default: u.store = 1'b0;
		endcase
		u.z    = (u.res == 8'h00);
		u.skip = ((u.op == CFI_OP_SZ) || (u.op == CFI_OP_SIZ) || (u.op == CFI_OP_SDZ))
			? u.z : ((u.op == CFI_OP_SNZ) && !u.z);
	end
endmodule

// ### verilog/cfi_irq_arb.sv
// fixed-priority interrupt arbiter: lowest source index wins
`timescale 1ns/1ps
module cfi_irq_arb (
	cfi_core_if.arb u
);
	import cfi_pkg::*;

	logic [CFI_NUM_SRC-1:0] elig;

	// isolating the lowest set bit gives external first, then timer 0, then timer 1
	always_comb
	begin
		elig   = u.pend & u.allow;
		u.sel  = elig & CFI_NUM_SRC'(~elig + 1'b1);
		u.take = u.boundary && u.gie && !u.stack_full && (|elig);
	end
endmodule

// ### verilog/cfi_core.sv
// core datapath: indirect access, working register, flags and interrupt entry
`timescale 1ns/1ps
module cfi_core #(
	parameter int RAM_DEPTH = 224
) (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire cfi_pkg::cfi_cmd_t    dm_cmd,
	input  wire logic [7:0]           dm_addr,
	input  wire logic [7:0]           imm,
	input  wire cfi_pkg::cfi_alu_op_t alu_op,
	input  wire logic                 alu_src_imm,
	input  wire logic                 alu_dst_mem,
	input  wire logic                 halt_op,
	input  wire logic                 wdt_clear_op,
	input  wire logic                 wdt_timeout,
	input  wire logic                 return_from_irq_op,
	input  wire logic                 ext_irq_pin,
	input  wire logic                 timer0_ovf,
	input  wire logic                 timer1_ovf,
	input  wire logic                 stack_full,
	input  wire logic                 instr_boundary,
	output logic [7:0]                rd_data,
	output logic                      skip_next,
	output logic                      irq_ack,
	output logic [7:0]                irq_vector,
	output logic                      wake_req,
	output logic                      halted,
	output logic [7:0]                flags_out
);
	import cfi_pkg::*;

	typedef struct packed {
		logic [RAM_DEPTH-1:0][7:0]   ram;
		logic [7:0]                  ptr0;
		logic [7:0]                  ptr1;
		logic [7:0]                  wreg;
		logic [3:0]                  arith;
		logic                        halted;
		logic                        wdx;
		logic                        gie;
		logic [CFI_NUM_SRC-1:0]      allow;
		logic [CFI_NUM_SRC-1:0]      pend;
		logic [2:0]                  ext_sync;
		logic                        ext_lvl;
		logic                        ack;
		logic [7:0]                  vec;
		logic [7:0]                  rdata;
		logic                        skip;
	} cfi_state_t;

	localparam cfi_state_t ST_RST = '{
		ram: '0, ptr0: CFI_RST_BYTE, ptr1: CFI_RST_BYTE, wreg: CFI_RST_BYTE,
		arith: '0, halted: 1'b0, wdx: 1'b0, gie: 1'b0, allow: '0, pend: '0,
		ext_sync: {3{CFI_RST_PIN}}, ext_lvl: CFI_RST_PIN, ack: 1'b0,
		vec: CFI_RST_BYTE, rdata: CFI_RST_BYTE, skip: 1'b0
	};

	cfi_state_t s_q;
	cfi_state_t s_d;
	logic [7:0] eff;
	logic       nul;
	logic [7:0] mem_val;
	logic       ext_fall;
	logic [CFI_NUM_SRC-1:0] hw_set;

	cfi_core_if u ();

	cfi_alu u_alu (
		.u (u.alu)
	);

	cfi_irq_arb u_arb (
		.u (u.arb)
	);

	// pointer redirection: the two ports hold no storage of their own
	function automatic logic [7:0] resolve(input logic [7:0] a, input cfi_state_t x);
		logic [7:0] r;
		r = a;
		if (a == CFI_ADDR_IND0)
			r = x.ptr0;
		else if (a == CFI_ADDR_IND1)
			r = x.ptr1;
		return r;
	endfunction

	// byte as seen on the data space; unmapped locations read zero
	function automatic logic [7:0] peek(input logic [7:0] a, input logic z,
		input cfi_state_t x);
		logic [7:0] r;
		r = 8'h00;
		if (!z)
		begin
			case (a)
				CFI_ADDR_PTR0:  r = x.ptr0;
				CFI_ADDR_PTR1:  r = x.ptr1;
				CFI_ADDR_WREG:  r = x.wreg;
				CFI_ADDR_FLAGS: r = {2'b00, x.wdx, x.halted, x.arith};
				CFI_ADDR_ICR:   r = {1'b0, x.pend, x.allow, x.gie};
				default:
					if ((a >= CFI_ADDR_RAM) && (32'(a - CFI_ADDR_RAM) < RAM_DEPTH))
						r = x.ram[a - CFI_ADDR_RAM];
			endcase
		end
		return r;
	endfunction

	// software store; flag writes touch only the arithmetic bits
	function automatic cfi_state_t poke(input cfi_state_t x, input logic [7:0] a,
		input logic z, input logic [7:0] d);
		cfi_state_t y;
		y = x;
		if (!z)
		begin
			case (a)
				CFI_ADDR_PTR0:  y.ptr0 = d;
				CFI_ADDR_PTR1:  y.ptr1 = d;
				CFI_ADDR_WREG:  y.wreg = d;
				CFI_ADDR_FLAGS: y.arith = d[3:0];
				CFI_ADDR_ICR:
				begin
					y.gie   = d[CFI_ICR_GIE];
					y.allow = d[CFI_ICR_ALLOW_LO +: CFI_NUM_SRC];
					y.pend  = d[CFI_ICR_PEND_LO +: CFI_NUM_SRC];
				end
				default:
					if ((a >= CFI_ADDR_RAM) && (32'(a - CFI_ADDR_RAM) < RAM_DEPTH))
						y.ram[a - CFI_ADDR_RAM] = d;
			endcase
		end
		return y;
	endfunction

	// operand and arbiter feeds come straight from the registered state and the module inputs
	always_comb
	begin
		eff          = resolve(dm_addr, s_q);
		nul          = (eff == CFI_ADDR_IND0) || (eff == CFI_ADDR_IND1);
		mem_val      = peek(eff, nul, s_q);
		u.op         = alu_op;
		u.a          = s_q.wreg;
		u.b          = alu_src_imm ? imm : mem_val;
		u.cin_c      = s_q.arith[CFI_FLG_CARRY];
		u.cin_ac     = s_q.arith[CFI_FLG_HALF];
		u.pend       = s_q.pend;
		u.allow      = s_q.allow;
		u.gie        = s_q.gie;
		u.stack_full = stack_full;
		u.boundary   = instr_boundary;
	end

	// pin edge is taken only once the second and third stages agree
	always_comb
	begin
		ext_fall = s_q.ext_lvl && (s_q.ext_sync[2:1] == 2'b00);
		hw_set   = {timer1_ovf, timer0_ovf, ext_fall};
	end

	// whole next state of the block
	always_comb
	begin
		s_d          = s_q;
		s_d.ack      = 1'b0;
		s_d.skip     = 1'b0;
		s_d.ext_sync = {s_q.ext_sync[1:0], ext_irq_pin};
		if (s_q.ext_sync[1] == s_q.ext_sync[2])
			s_d.ext_lvl = s_q.ext_sync[2];

		// loads and stores go through the working register; a read only fills rdata
		case (dm_cmd)
			CFI_CMD_READ:  s_d.rdata = mem_val;
			CFI_CMD_LOAD:  s_d.wreg = mem_val;
			CFI_CMD_STORE: s_d = poke(s_d, eff, nul, s_q.wreg);
			CFI_CMD_IMM:   s_d.wreg = imm;
			CFI_CMD_ALU:
			begin
				if (u.store)
				begin
					if (alu_dst_mem)
						s_d = poke(s_d, eff, nul, u.res);
					else
						s_d.wreg = u.res;
				end
				// flag update follows the store so it wins when the target is 0AH
				if (u.m_c)
					s_d.arith[CFI_FLG_CARRY] = u.c;
				if (u.m_av)
				begin
					s_d.arith[CFI_FLG_HALF]  = u.ac;
					s_d.arith[CFI_FLG_RANGE] = u.ov;
				end
				if (u.m_z)
					s_d.arith[CFI_FLG_ZERO] = u.z;
				s_d.skip = u.skip;
			end
			default: ;
		endcase

		// power-down and watchdog bits have their own few causes only
		if (halt_op)
		begin
			s_d.halted = 1'b1;
			s_d.wdx    = 1'b0;
		end
		if (wdt_clear_op)
		begin
			s_d.halted = 1'b0;
			s_d.wdx    = 1'b0;
		end
		if (wdt_timeout)
			s_d.wdx = 1'b1;

		if (return_from_irq_op)
			s_d.gie = 1'b1;

		// entry touches only enable, pending, ack and vector; the flags are not saved
		if (u.take)
		begin
			s_d.ack  = 1'b1;
			s_d.gie  = 1'b0;
			s_d.pend = s_d.pend & ~u.sel;
			s_d.vec  = u.sel[0] ? CFI_VEC_EXT : (u.sel[1] ? CFI_VEC_T0 : CFI_VEC_T1);
		end
		// late hardware set so a request is never lost to a clear
		s_d.pend = s_d.pend | hw_set;
	end

	// single state register
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			s_q <= ST_RST;
		else
			s_q <= s_d;
	end

	// any pending request wakes a halted core, enabled or not
	always_comb
	begin
		rd_data    = s_q.rdata;
		skip_next  = s_q.skip;
		irq_ack    = s_q.ack;
		irq_vector = s_q.vec;
		halted     = s_q.halted;
		flags_out  = {2'b00, s_q.wdx, s_q.halted, s_q.arith};
		wake_req   = s_q.halted && (|s_q.pend);
	end

	// one clock domain, so every check shares the default clock and reset;
	// the checks combine registered state with the bench's own drives
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence ext_ready;
		instr_boundary && s_q.gie && !stack_full && s_q.pend[0] && s_q.allow[0] && !return_from_irq_op;
	endsequence

	sequence t0_only_ready;
		instr_boundary && s_q.gie && !stack_full && !return_from_irq_op &&
			s_q.pend[1] && s_q.allow[1] && !(s_q.pend[0] && s_q.allow[0]);
	endsequence

	sequence t1_only_ready;
		instr_boundary && s_q.gie && !stack_full && !return_from_irq_op && s_q.pend[2] && s_q.allow[2] &&
			!(s_q.pend[0] && s_q.allow[0]) && !(s_q.pend[1] && s_q.allow[1]);
	endsequence

	a_ind_self_zero: assert property (
		(dm_cmd == CFI_CMD_READ) && (dm_addr == CFI_ADDR_IND0) && (s_q.ptr0 == CFI_ADDR_IND1)
		|=> rd_data == 8'h00) else $error("self-indirect read not zero");

	a_ptr_redirect: assert property (
		(dm_cmd == CFI_CMD_READ) && (dm_addr == CFI_ADDR_IND1) && (s_q.ptr1 == CFI_ADDR_WREG)
		|=> rd_data == $past(s_q.wreg)) else $error("indirect read not redirected");

	a_flag_write_keep: assert property (
		(dm_cmd == CFI_CMD_STORE) && (dm_addr == CFI_ADDR_FLAGS) &&
		!halt_op && !wdt_clear_op && !wdt_timeout
		|=> $stable(halted) && $stable(flags_out[CFI_FLG_WDX])
		&& flags_out[3:0] == $past(s_q.wreg[3:0])) else $error("flag write hit halt bits");

	a_add_carry: assert property (
		(dm_cmd == CFI_CMD_ALU) && (alu_op == CFI_OP_ADD) && alu_src_imm
		|=> flags_out[CFI_FLG_CARRY] == $past(9'({1'b0, s_q.wreg} + {1'b0, imm}) >> 8))
		else $error("carry after add wrong");

	a_halt_flags: assert property (
		halt_op && !wdt_clear_op && !wdt_timeout
		|=> halted && !flags_out[CFI_FLG_WDX] && flags_out[7:6] == 2'b00)
		else $error("halt did not set power-down state");

	a_wdt_expire: assert property (
		wdt_timeout |=> flags_out[CFI_FLG_WDX] ##1 (flags_out[CFI_FLG_WDX] || $past(halt_op)
		|| $past(wdt_clear_op))) else $error("watchdog flag lost");

	a_ext_service: assert property (
		ext_ready |=> irq_ack && irq_vector == CFI_VEC_EXT && !s_q.gie)
		else $error("external entry wrong");

	a_t0_service: assert property (
		t0_only_ready |=> irq_ack && irq_vector == CFI_VEC_T0 && !s_q.gie)
		else $error("timer 0 entry wrong");

	a_no_ack_full: assert property (
		stack_full |=> !irq_ack) else $error("acknowledge with full stack");

	a_pend_set_wins: assert property (
		timer0_ovf && (dm_cmd == CFI_CMD_STORE) && (dm_addr == CFI_ADDR_ICR)
		|=> s_q.pend[1]) else $error("timer 0 request lost to clear");

	a_ext_edge: assert property (
		$fell(s_q.ext_lvl) |-> s_q.pend[0]) else $error("pin edge not recorded");

	a_return_from_irq_enable: assert property (
		return_from_irq_op |=> s_q.gie || irq_ack) else $error("return did not re-enable");

	a_wake_any: assert property (
		halted && timer1_ovf && !wdt_clear_op |=> wake_req) else $error("no wake on request");

	a_ack_single: assert property (
		irq_ack |=> !irq_ack) else $error("acknowledge longer than one cycle");

	a_t1_service: assert property (
		t1_only_ready |=> irq_ack && irq_vector == CFI_VEC_T1 && !s_q.gie)
		else $error("timer 1 entry wrong");

	a_ind_write_void: assert property (
		(dm_cmd == CFI_CMD_STORE) && (dm_addr == CFI_ADDR_IND0) && (s_q.ptr0 == CFI_ADDR_IND1)
		|=> $stable(s_q.ram) && $stable(s_q.ptr0) && $stable(s_q.ptr1) && $stable(s_q.wreg))
		else $error("self-indirect write changed state");

	a_skip_idle: assert property (
		(dm_cmd != CFI_CMD_ALU) |=> !skip_next) else $error("skip without a test");

	a_gie_off: assert property (
		!s_q.gie |=> !irq_ack) else $error("acknowledge while disabled");

	a_wreg_imm: assert property (
		(dm_cmd == CFI_CMD_IMM) |=> s_q.wreg == $past(imm)) else $error("immediate not loaded");

	a_vec_hold: assert property (
		!u.take |=> $stable(irq_vector)) else $error("vector moved without entry");

	a_halt_stay: assert property (
		halted && !wdt_clear_op |=> halted) else $error("halted flag lost");

	a_wdx_cause: assert property (
		!wdt_timeout |=> !$rose(flags_out[CFI_FLG_WDX])) else $error("watchdog flag set alone");

endmodule

// ### verification/cfi_seq_model.sv
// return-address stack model of the sequencer: depth count and full level
`timescale 1ns/1ps
module cfi_seq_model #(
	parameter int DEPTH = 16
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic irq_ack,
	input  wire logic call_op,
	input  wire logic ret_op,
	output logic      stack_full
);
	int level_q;

	// pushes saturate at full, as the real stack drops its oldest entry there
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			level_q <= 0;
		else if ((irq_ack || call_op) && !ret_op && level_q < DEPTH)
			level_q <= level_q + 1;
		else if (ret_op && !(irq_ack || call_op) && level_q > 0)
			level_q <= level_q - 1;
	end

	// full level holds off acknowledges until a return pops an entry
	assign stack_full = (level_q == DEPTH);
endmodule

// ### verification/core_flags_indirect_irq_test.sv
// self-checking bench for the flags, indirect access and interrupt datapath
`timescale 1ns/1ps
module core_flags_indirect_irq_test;
	import cfi_pkg::*;

	typedef struct packed {
		cfi_alu_op_t op;
		logic [7:0]  pre;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [7:0]  res;
		logic [3:0]  flg;
		logic        skp;
	} cfi_vec_t;

	// preset flags, operands, result and {ov,z,ac,c} after each operation
	localparam cfi_vec_t VECS [20] = '{
		'{CFI_OP_ADD, 8'h00, 8'h8f, 8'h71, 8'h00, 4'h7, 1'b0},
		'{CFI_OP_ADD, 8'h00, 8'h7f, 8'h01, 8'h80, 4'ha, 1'b0},
		'{CFI_OP_ADC, 8'h01, 8'h10, 8'h20, 8'h31, 4'h0, 1'b0},
		'{CFI_OP_SUB, 8'h00, 8'h05, 8'h03, 8'h02, 4'h3, 1'b0},
		'{CFI_OP_SBC, 8'h00, 8'h05, 8'h05, 8'hff, 4'h0, 1'b0},
		'{CFI_OP_DAA, 8'h00, 8'h00, 8'h9a, 8'h00, 4'h1, 1'b0},
		'{CFI_OP_AND, 8'h0b, 8'hf0, 8'h0f, 8'h00, 4'hf, 1'b0},
		'{CFI_OP_OR,  8'h00, 8'h00, 8'h00, 8'h00, 4'h4, 1'b0},
		'{CFI_OP_XOR, 8'h00, 8'h5a, 8'h5a, 8'h00, 4'h4, 1'b0},
		'{CFI_OP_CPL, 8'h00, 8'h00, 8'hff, 8'h00, 4'h4, 1'b0},
		'{CFI_OP_RL,  8'h00, 8'h00, 8'h81, 8'h03, 4'h0, 1'b0},
		'{CFI_OP_RR,  8'h00, 8'h00, 8'h01, 8'h80, 4'h0, 1'b0},
		'{CFI_OP_RLC, 8'h00, 8'h00, 8'h80, 8'h00, 4'h1, 1'b0},
		'{CFI_OP_RRC, 8'h01, 8'h00, 8'h01, 8'h80, 4'h1, 1'b0},
		'{CFI_OP_INC, 8'h01, 8'h00, 8'hff, 8'h00, 4'h5, 1'b0},
		'{CFI_OP_DEC, 8'h00, 8'h00, 8'h01, 8'h00, 4'h4, 1'b0},
		'{CFI_OP_SZ,  8'h00, 8'h33, 8'h00, 8'h33, 4'h0, 1'b1},
		'{CFI_OP_SNZ, 8'h00, 8'h33, 8'h00, 8'h33, 4'h0, 1'b0},
		'{CFI_OP_SIZ, 8'h00, 8'h00, 8'hff, 8'h00, 4'h0, 1'b1},
		'{CFI_OP_SDZ, 8'h00, 8'h00, 8'h05, 8'h04, 4'h0, 1'b0}};

	// event bits {halt, wclr, wto, return_from_irq, t0, t1, call, ret}
	localparam logic [7:0] EV_HALT = 8'h80;
	localparam logic [7:0] EV_WCLR = 8'h40;
	localparam logic [7:0] EV_WTO  = 8'h20;
	localparam logic [7:0] EV_RETURN_FROM_IRQ = 8'h11;
	localparam logic [7:0] EV_T0   = 8'h08;
	localparam logic [7:0] EV_T1   = 8'h04;
	localparam logic [7:0] EV_CALL = 8'h02;
	localparam logic [7:0] EV_RET  = 8'h01;

	logic        clk            = 1'b0;
	logic        rst_b          = 1'b0;
	cfi_cmd_t    dm_cmd         = CFI_CMD_NOP;
	logic [7:0]  dm_addr        = 8'h00;
	logic [7:0]  imm            = 8'h00;
	cfi_alu_op_t alu_op         = CFI_OP_ADD;
	logic        halt_op        = 1'b0;
	logic        wdt_clear_op   = 1'b0;
	logic        wdt_timeout    = 1'b0;
	logic        return_from_irq_op        = 1'b0;
	logic        ext_irq_pin    = 1'b1;
	logic        timer0_ovf     = 1'b0;
	logic        timer1_ovf     = 1'b0;
	logic        instr_boundary = 1'b0;
	logic        alu_src_imm    = 1'b1;
	logic        alu_dst_mem    = 1'b0;
	logic        call_op        = 1'b0;
	logic        ret_op         = 1'b0;
	logic        stack_full;
	logic [7:0]  rd_data;
	logic        skip_next;
	logic        irq_ack;
	logic [7:0]  irq_vector;
	logic        wake_req;
	logic        halted;
	logic [7:0]  flags_out;
	logic [7:0]  flags_before;
	int          err_count      = 0;
	int          comparisons    = 0;
	int          ack_count      = 0;
	int          cycles         = 0;

	cfi_core cfi_core_i (
		.clk(clk), .rst_b(rst_b), .dm_cmd(dm_cmd), .dm_addr(dm_addr), .imm(imm),
		.alu_op(alu_op), .alu_src_imm(alu_src_imm), .alu_dst_mem(alu_dst_mem),
		.halt_op(halt_op),
		.wdt_clear_op(wdt_clear_op), .wdt_timeout(wdt_timeout), .return_from_irq_op(return_from_irq_op),
		.ext_irq_pin(ext_irq_pin), .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf),
		.stack_full(stack_full), .instr_boundary(instr_boundary), .rd_data(rd_data),
		.skip_next(skip_next), .irq_ack(irq_ack), .irq_vector(irq_vector),
		.wake_req(wake_req), .halted(halted), .flags_out(flags_out)
	);

	cfi_seq_model cfi_seq_model_i (
		.clk(clk), .rst_b(rst_b), .irq_ack(irq_ack), .call_op(call_op),
		.ret_op(ret_op), .stack_full(stack_full)
	);

	initial
	begin
		forever #12.5 clk = ~clk;
	end

	// acknowledges counted at the settled half of the cycle
	always @(negedge clk)
	begin
		if (irq_ack === 1'b1)
			ack_count++;
	end

	// ceiling far above the fewer than two hundred cycles the sequence needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_count++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one command cycle; called at a falling edge, returns at the next one
	task automatic put(input cfi_cmd_t c, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] ev = 8'h00, input cfi_alu_op_t o = CFI_OP_ADD);
		dm_cmd = c;
		dm_addr = a;
		imm = d;
		alu_op = o;
		{halt_op, wdt_clear_op, wdt_timeout, return_from_irq_op} = ev[7:4];
		{timer0_ovf, timer1_ovf, call_op, ret_op} = ev[3:0];
		@(negedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		put(CFI_CMD_READ, a, 8'h00);
		chk("rd_data", rd_data, exp);
	endtask

	// bounded wait: the acknowledge is a one-cycle pulse
	task automatic wait_ack(input logic [7:0] v);
		int n;
		n = 0;
		while (irq_ack !== 1'b1 && n < 10)
		begin
			@(negedge clk);
			n++;
		end
		chk("irq_ack", {7'h00, irq_ack}, 8'h01);
		chk("irq_vector", irq_vector, v);
	endtask

	task automatic end_sim;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		chk("flags_out", flags_out, 8'h00);
		put(CFI_CMD_IMM, 8'h00, 8'h5a);
		put(CFI_CMD_STORE, 8'h20, 8'h00);
		rd(8'h20, 8'h5a);
		rd(CFI_ADDR_WREG, 8'h5a);
		// pointers steer 00H and 02H, out to the top byte of the space
		put(CFI_CMD_IMM, 8'h00, 8'hff);
		put(CFI_CMD_STORE, CFI_ADDR_PTR0, 8'h00);
		put(CFI_CMD_IMM, 8'h00, 8'h77);
		put(CFI_CMD_STORE, CFI_ADDR_IND0, 8'h00);
		rd(8'hff, 8'h77);
		rd(CFI_ADDR_IND0, 8'h77);
		put(CFI_CMD_IMM, 8'h00, 8'h40);
		put(CFI_CMD_STORE, CFI_ADDR_PTR1, 8'h00);
		put(CFI_CMD_IMM, 8'h00, 8'h3c);
		put(CFI_CMD_STORE, CFI_ADDR_IND1, 8'h00);
		rd(8'h40, 8'h3c);
		// pointer 0 aimed at 02H must not chain through pointer 1
		put(CFI_CMD_IMM, 8'h00, 8'h02);
		put(CFI_CMD_STORE, CFI_ADDR_PTR0, 8'h00);
		put(CFI_CMD_IMM, 8'h00, 8'h99);
		put(CFI_CMD_STORE, CFI_ADDR_IND0, 8'h00);
		rd(CFI_ADDR_IND0, 8'h00);
		rd(8'h40, 8'h3c);
		// every ALU operation from a known flag preset
		foreach (VECS[i])
		begin
			put(CFI_CMD_IMM, 8'h00, VECS[i].pre);
			put(CFI_CMD_STORE, CFI_ADDR_FLAGS, 8'h00);
			put(CFI_CMD_IMM, 8'h00, VECS[i].a);
			put(CFI_CMD_ALU, 8'h00, VECS[i].b, 8'h00, VECS[i].op);
			chk("skip_next", {7'h00, skip_next}, {7'h00, VECS[i].skp});
			rd(CFI_ADDR_WREG, VECS[i].res);
			chk("flags", flags_out, {4'h0, VECS[i].flg});
		end
		// software writes never reach halted, watchdog or unused bits
		put(CFI_CMD_IMM, 8'h00, 8'hff);
		put(CFI_CMD_STORE, CFI_ADDR_FLAGS, 8'h00);
		rd(CFI_ADDR_FLAGS, 8'h0f);
		put(CFI_CMD_IMM, 8'h00, 8'h00, EV_HALT);
		chk("flags", flags_out, 8'h1f);
		put(CFI_CMD_STORE, CFI_ADDR_FLAGS, 8'h00);
		chk("flags", flags_out, 8'h10);
		put(CFI_CMD_NOP, 8'h00, 8'h00, EV_WTO);
		chk("flags", flags_out, 8'h30);
		put(CFI_CMD_NOP, 8'h00, 8'h00, EV_HALT);
		chk("flags", flags_out, 8'h10);
		put(CFI_CMD_NOP, 8'h00, 8'h00, EV_WTO);
		put(CFI_CMD_NOP, 8'h00, 8'h00, EV_WCLR);
		chk("flags", flags_out, 8'h00);
		put(CFI_CMD_NOP, 8'h00, 8'h00, EV_HALT);
		chk("halted", {7'h00, halted}, 8'h01);
		// enable global, external and timer 0 sources, then raise requests
		put(CFI_CMD_IMM, 8'h00, 8'h07);
		put(CFI_CMD_STORE, CFI_ADDR_ICR, 8'h00);
		rd(CFI_ADDR_ICR, 8'h07);
		chk("wake_req", {7'h00, wake_req}, 8'h00);
		put(CFI_CMD_NOP, 8'h00, 8'h00, EV_T0);
		put(CFI_CMD_NOP, 8'h00, 8'h00, EV_T1);
		chk("wake_req", {7'h00, wake_req}, 8'h01);
		rd(CFI_ADDR_ICR, 8'h67);
		ext_irq_pin = 1'b0;
		repeat (6) put(CFI_CMD_NOP, 8'h00, 8'h00);
		rd(CFI_ADDR_ICR, 8'h77);
		ext_irq_pin = 1'b1;
		// full stack holds every acknowledge off until a return
		repeat (16) put(CFI_CMD_NOP, 8'h00, 8'h00, EV_CALL);
		instr_boundary = 1'b1;
		repeat (8) put(CFI_CMD_NOP, 8'h00, 8'h00);
		chk("ack_count", ack_count[7:0], 8'h00);
		flags_before = flags_out;
		put(CFI_CMD_NOP, 8'h00, 8'h00, EV_RET);
		put(CFI_CMD_NOP, 8'h00, 8'h00);
		wait_ack(CFI_VEC_EXT);
		chk("flags_out", flags_out, flags_before);
		rd(CFI_ADDR_ICR, 8'h66);
		put(CFI_CMD_NOP, 8'h00, 8'h00, EV_RETURN_FROM_IRQ);
		put(CFI_CMD_NOP, 8'h00, 8'h00);
		wait_ack(CFI_VEC_T0);
		rd(CFI_ADDR_ICR, 8'h46);
		put(CFI_CMD_NOP, 8'h00, 8'h00, EV_T0);
		rd(CFI_ADDR_ICR, 8'h66);
		// software clear meets a hardware set in the same cycle
		put(CFI_CMD_IMM, 8'h00, 8'h06);
		put(CFI_CMD_STORE, CFI_ADDR_ICR, 8'h00, EV_T0);
		rd(CFI_ADDR_ICR, 8'h26);
		// timer 1 alone, admitted once a return frees a stack level
		put(CFI_CMD_IMM, 8'h00, 8'h49);
		put(CFI_CMD_STORE, CFI_ADDR_ICR, 8'h00);
		put(CFI_CMD_NOP, 8'h00, 8'h00, EV_RET);
		put(CFI_CMD_NOP, 8'h00, 8'h00);
		wait_ack(CFI_VEC_T1);
		rd(CFI_ADDR_ICR, 8'h08);
		// memory operand and memory target, reached through pointer 1
		alu_src_imm = 1'b0;
		alu_dst_mem = 1'b1;
		put(CFI_CMD_ALU, CFI_ADDR_IND1, 8'h00, 8'h00, CFI_OP_INC);
		alu_src_imm = 1'b1;
		alu_dst_mem = 1'b0;
		rd(8'h40, 8'h3d);
		put(CFI_CMD_LOAD, 8'h40, 8'h00);
		rd(CFI_ADDR_WREG, 8'h3d);
		// pointer 1 aimed at the working register
		put(CFI_CMD_IMM, 8'h00, CFI_ADDR_WREG);
		put(CFI_CMD_STORE, CFI_ADDR_PTR1, 8'h00);
		rd(CFI_ADDR_IND1, CFI_ADDR_WREG);
		put(CFI_CMD_NOP, 8'h00, 8'h00);
		end_sim();
	end
endmodule
